// ---- rtl/sco_cfg.svh ----
`ifndef SCO_CFG_SVH
`define SCO_CFG_SVH

// ****************************************
// Register word indexes (byte address = 4 * index)
// ****************************************
`define SCO_A_CTRL  3'h0
`define SCO_A_BUF   3'h1
`define SCO_A_STS   3'h2
`define SCO_A_CLR   3'h3
`define SCO_A_IEN   3'h4

// ****************************************
// Control register fields and reset value
// ****************************************
`define SCO_B_WRITE_COLLISION_FLAG  7
`define SCO_B_OVF   6
`define SCO_B_EN    5
`define SCO_B_CKP   4
`define SCO_CTRL_RST 8'h00

// ****************************************
// Interrupt status bits
// ****************************************
`define SCO_I_WRITE_COLLISION_FLAG  0
`define SCO_I_OVF   1
`define SCO_I_DONE  2

// ****************************************
// Mode codes and master half-period counts
// ****************************************
`define SCO_M_DIV4   4'h0
`define SCO_M_DIV16  4'h1
`define SCO_M_DIV64  4'h2
`define SCO_M_TMR    4'h3
`define SCO_M_SLV_SS 4'h4
`define SCO_M_SLV    4'h5
`define SCO_HALF_4   7'h02
`define SCO_HALF_16  7'h08
`define SCO_HALF_64  7'h20
`define SCO_HALF_TMR 7'h40
`define SCO_BITS     4'h8

`endif

// ---- rtl/sco_pkg.sv ----
package sco_pkg;

  typedef enum logic [0:0] {
    SCO_IDLE,
    SCO_SHIFT
  } sco_state_t;

endpackage

// ---- rtl/sco_top.sv ----
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`include "sco_cfg.svh"

// Notes on behaviour
// R1 - A transfer-buffer write while a word is still shifting sets control bit 7 until cleared.
// R2 - In slave mode a byte completing while the buffer is still unread sets control bit 6.
// R3 - On such an overflow the new byte is dropped and the buffer keeps the older byte.
// R4 - The overflow flag is never raised by hardware while the port is a master.
// R5 - In slave mode software must read the buffer after every byte, even when only transmitting.
// R6 - The overflow flag stays set until software writes it to zero.
// R7 - Modes 0100 and 0101 are slave modes on the pin clock, 0100 with select, 0000-0011 master.
module sco_top
  import sco_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        spi_sck_in,
  output logic             spi_sck_out,
  output logic             spi_sck_oe,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  input  wire logic        spi_ss_n,
  output logic             irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
    shift_in = {v[6:0], b};
  endfunction

  function automatic logic [6:0] half_of(input logic [3:0] m);
    case (m)
      `SCO_M_DIV4:  half_of = `SCO_HALF_4;
      `SCO_M_DIV16: half_of = `SCO_HALF_16;
      `SCO_M_DIV64: half_of = `SCO_HALF_64;
      default:      half_of = `SCO_HALF_TMR;
    endcase
  endfunction

  logic [7:0]  ctrl_r;
  logic [7:0]  buf_r;
  logic        full_r;
  logic [7:0]  sh_r;
  logic [3:0]  cnt_r;
  logic [6:0]  div_r;
  logic        sck_r;
  logic        sdo_r;
  logic        oe_r;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [2:0]  sts_r;
  logic [2:0]  ien_r;
  logic        irq_r;
  logic [2:0]  s1_r;
  logic [2:0]  s2_r;
  logic [2:0]  s3_r;
  logic [2:0]  lvl_r;
  logic        sck_q_r;
  sco_state_t  st_r;

  // ****************************************
  // Bus decode and mode
  // ****************************************
  logic       acc;
  logic       wr_ctrl;
  logic       wr_buf;
  logic       rd_buf;
  logic       en;
  logic       clock_polarity_bit;
  logic [3:0] mode;
  logic       master;
  logic       slave;
  logic       busy;
  logic       tick;
  logic       m_lead;
  logic       m_trail;
  logic       s_lead;
  logic       s_trail;
  logic       done;
  logic [7:0] done_val;
  logic       ovf_ev;
  logic       write_collision_flag_ev;

  assign acc     = (avs_read | avs_write) & ~wait_r;
  assign wr_ctrl = acc & avs_write & (avs_address == `SCO_A_CTRL);
  assign wr_buf  = acc & avs_write & (avs_address == `SCO_A_BUF);
  assign rd_buf  = acc & avs_read & (avs_address == `SCO_A_BUF);
  assign en      = ctrl_r[`SCO_B_EN];
  assign clock_polarity_bit     = ctrl_r[`SCO_B_CKP];
  assign mode    = ctrl_r[3:0];
  assign master  = en & (mode[3:2] == 2'h0); // R7
  // Select pin only counts in the select-controlled slave code
  assign slave   = en & ((mode == `SCO_M_SLV) | ((mode == `SCO_M_SLV_SS) & ~lvl_r[2])); // R7
  assign busy    = master ? (st_r == SCO_SHIFT) : (slave & (cnt_r != 4'h0));
  assign tick    = (st_r == SCO_SHIFT) & (div_r == half_of(mode) - 7'h01);
  assign m_lead  = master & tick & (sck_r == clock_polarity_bit);
  assign m_trail = master & tick & (sck_r != clock_polarity_bit);
  assign s_lead  = slave & (sck_q_r == clock_polarity_bit) & (lvl_r[0] != clock_polarity_bit);
  assign s_trail = slave & (sck_q_r != clock_polarity_bit) & (lvl_r[0] == clock_polarity_bit);
  assign done    = (m_trail & (cnt_r == `SCO_BITS)) | (s_lead & (cnt_r == `SCO_BITS - 4'h1));
  assign done_val = master ? sh_r : shift_in(sh_r, lvl_r[1]);
  assign ovf_ev  = done & slave & full_r; // R2 R4
  assign write_collision_flag_ev = wr_buf & busy; // R1

  // ****************************************
  // Avalon slave: one wait cycle, then one answer cycle
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~((avs_read | avs_write) & wait_r);
      if ((avs_read | avs_write) & wait_r) begin
        case (avs_address)
          `SCO_A_CTRL: rdata_r <= {24'h00_0000, ctrl_r};
          `SCO_A_BUF:  rdata_r <= {24'h00_0000, buf_r};
          `SCO_A_STS:  rdata_r <= {29'h0000_0000, sts_r};
          `SCO_A_IEN:  rdata_r <= {29'h0000_0000, ien_r};
          default:     rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Control register and error flags
  // ****************************************
  // Flags are plain read/write bits; an event in the clearing cycle still sets them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r <= `SCO_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= avs_writedata[7:0];
      end
      if (write_collision_flag_ev) begin
        ctrl_r[`SCO_B_WRITE_COLLISION_FLAG] <= 1'b1; // R1
      end
      if (ovf_ev) begin
        ctrl_r[`SCO_B_OVF] <= 1'b1; // R2 R6
      end
    end
  end

  // ****************************************
  // Pin synchronisers: sck, sdi, select
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r    <= 3'h6;
      s2_r    <= 3'h6;
      s3_r    <= 3'h6;
      lvl_r   <= 3'h6;
      sck_q_r <= 1'b0;
    end else begin
      s1_r    <= {spi_ss_n, spi_sdi, spi_sck_in};
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      lvl_r   <= (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
      sck_q_r <= lvl_r[0];
    end
  end

  // ****************************************
  // Shifter, master clock and receive buffer
  // ****************************************
  // Busy writes are refused; a slave write in the first leading-edge cycle (cnt_r still 0) is taken and that bit is lost
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r   <= SCO_IDLE;
      sh_r   <= 8'h00;
      cnt_r  <= 4'h0;
      div_r  <= 7'h00;
      sck_r  <= 1'b0;
      sdo_r  <= 1'b0;
      oe_r   <= 1'b0;
      buf_r  <= 8'h00;
      full_r <= 1'b0;
    end else begin
      oe_r <= master; // R7
      if (st_r == SCO_IDLE) begin
        sck_r <= clock_polarity_bit;
      end
      div_r <= (tick | (st_r == SCO_IDLE)) ? 7'h00 : div_r + 7'h01;
      if (rd_buf) begin
        full_r <= 1'b0;
      end
      if (wr_buf & ~busy & en) begin
        sh_r  <= avs_writedata[7:0];
        sdo_r <= avs_writedata[7];
        cnt_r <= 4'h0;
        if (master) begin
          st_r <= SCO_SHIFT;
        end
      end else if (m_lead | s_lead) begin
        sh_r  <= shift_in(sh_r, lvl_r[1]);
        cnt_r <= (s_lead & done) ? 4'h0 : cnt_r + 4'h1;
      end else if (m_trail | s_trail) begin
        sdo_r <= sh_r[7];
      end else if (!slave & !master) begin
        st_r  <= SCO_IDLE;
        cnt_r <= 4'h0;
      end
      if (tick) begin
        sck_r <= ~sck_r;
      end
      if (m_trail & done) begin
        st_r <= SCO_IDLE;
      end
      // On overflow buf_r is left alone and the new byte is dropped
      if (done & ~ovf_ev) begin // R3
        buf_r  <= done_val;
        full_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Interrupt status, clear, enable
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sts_r <= 3'h0;
      ien_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      if (acc & avs_write & (avs_address == `SCO_A_IEN)) begin
        ien_r <= avs_writedata[2:0];
      end
      sts_r <= (sts_r & ~((acc & avs_write & (avs_address == `SCO_A_CLR))
                          ? avs_writedata[2:0] : 3'h0))
               | {done & ~ovf_ev, ovf_ev, write_collision_flag_ev};
      irq_r <= |(sts_r & ien_r);
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign spi_sck_out     = sck_r;
  assign spi_sck_oe      = oe_r;
  assign spi_sdo         = sdo_r;
  assign irq             = irq_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_byte_over;
    done ##0 slave ##0 full_r;
  endsequence

  a_write_collision_flag_set: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    write_collision_flag_ev |=> ctrl_r[`SCO_B_WRITE_COLLISION_FLAG]) else $error("collision flag not set");
  a_ovf_set: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    s_byte_over |=> ctrl_r[`SCO_B_OVF]) else $error("overflow flag not set");
  a_ovf_keep_buf: assert property (@(posedge mclk) disable iff (!rst_n) // R3
    s_byte_over |=> buf_r == $past(buf_r)) else $error("buffer overwritten on overflow");
  a_ovf_master: assert property (@(posedge mclk) disable iff (!rst_n) // R4
    $rose(ctrl_r[`SCO_B_OVF]) |-> $past(wr_ctrl) || $past(slave))
    else $error("overflow raised in master mode");
  a_ovf_sticky: assert property (@(posedge mclk) disable iff (!rst_n) // R6
    ctrl_r[`SCO_B_OVF] && !wr_ctrl |=> ctrl_r[`SCO_B_OVF])
    else $error("overflow flag dropped by hardware");
  a_slave_no_drive: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    slave ##1 slave |-> !spi_sck_oe) else $error("slave drives clock");
  a_bus_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest) else $error("bus answer late");

endmodule

// ---- test/sco_spi_master_model.sv ----
// ****************************************
// Far-side SPI master driving the slave port
// ****************************************
module sco_spi_master_model (
  input  wire logic mclk,
  output logic      sck,
  output logic      sdi,
  output logic      ss_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sck  = 1'b0;
    sdi  = 1'b1;
    ss_n = 1'b1;
  end

  // Half period of 8 mclk leaves room for the three-flop pin synchronisers
  task automatic xfer(input logic [7:0] b, input logic sel);
    ss_n <= ~sel;
    for (int i = 7; i >= 0; i--) begin
      sdi <= b[i];
      repeat (8) @(posedge mclk);
      sck <= 1'b1;
      repeat (8) @(posedge mclk);
      sck <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    ss_n <= 1'b1;
    // Released data line shows the inverse, never the last bit
    sdi  <= ~b[0];
  endtask
endmodule

// ---- test/tb.sv ----
`include "sco_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic        sck, sdi, ss_n;
  logic        sck_o, sck_oe, sdo, sck_q;
  logic [7:0]  mo_sh;
  int          w, ckp_tb;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          n_mismatch, n_compared, seed, ctl, bufv, full;

  sco_top u_sco_top (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .spi_sck_in(sck), .spi_sck_out(sck_o),
    .spi_sck_oe(sck_oe), .spi_sdi(sdi), .spi_sdo(sdo), .spi_ss_n(ss_n), .irq(irq)
  );
  sco_spi_master_model u_sco_spi_master_model (.mclk(mclk), .sck(sck), .sdi(sdi), .ss_n(ss_n));

  always #4 mclk = ~mclk;

  // Far-side view of the master: data taken on each leading clock edge
  always @(posedge mclk) begin
    sck_q <= sck_o;
    if (sck_oe && sck_o != sck_q && sck_o != ckp_tb) mo_sh <= {mo_sh[6:0], sdo};
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [2:0] a, input int d);
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic poll(input int mask);
    q = 0;
    for (int k = 0; k < 600 && (q & mask) === 0; k++) bus(1'b0, `SCO_A_STS, 0);
  endtask

  task automatic rx(input logic sel);
    logic [7:0] b;
    b = 8'($random(seed));
    bus(1'b1, `SCO_A_CLR, 7);
    u_sco_spi_master_model.xfer(b, sel);
    poll(7);
    check("status", q, full ? 2 : 4);
    check("slave clock enable", sck_oe, 0);
    // Overflow drops the new byte and keeps the unread one
    if (full) ctl |= 32'h40;
    else bufv = b;
    full = 1;
  endtask

  task automatic rd_buf();
    bus(1'b0, `SCO_A_BUF, 0);
    check("buffer", q, bufv);
    full = 0;
  endtask

  task automatic conclude();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mclk = 0; rst_n = 0; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
    seed = 32'h6252cb23; ctl = 0; bufv = 0; full = 0; ckp_tb = 0; w = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, `SCO_A_CTRL, 0);
    check("control reset", q, 0);
    bus(1'b0, 3'h7, 0);
    check("unmapped", q, 0);
    ctl = 32'h24;
    bus(1'b1, `SCO_A_CTRL, ctl);
    rx(1'b1);
    check("masked irq", irq, 0);
    rd_buf();
    bus(1'b1, `SCO_A_IEN, 2);
    rx(1'b1);
    rx(1'b1);
    bus(1'b0, `SCO_A_CTRL, 0);
    check("control", q, ctl);
    check("irq", irq, 1);
    rd_buf();
    bus(1'b1, `SCO_A_CLR, 2);
    repeat (3) @(posedge mclk);
    check("irq cleared", irq, 0);
    rx(1'b1);
    bus(1'b0, `SCO_A_CTRL, 0);
    check("control", q, ctl);
    rd_buf();
    ctl = 32'h25;
    bus(1'b1, `SCO_A_CTRL, ctl);
    bus(1'b0, `SCO_A_CTRL, 0);
    check("control", q, ctl);
    rx(1'b0);
    rd_buf();
    // Master, every rate and both polarities: second write collides; no overflow
    for (int m = 0; m < 4; m++) begin
      ckp_tb = m & 1;
      ctl = 32'h20 | (ckp_tb << 4) | m;
      bus(1'b1, `SCO_A_CTRL, ctl);
      bus(1'b1, `SCO_A_CLR, 7);
      w = $random(seed) & 32'hff;
      bus(1'b1, `SCO_A_BUF, w);
      bus(1'b1, `SCO_A_BUF, $random(seed) & 32'hff);
      poll(4);
      check("status", q, 5);
      check("serial out", mo_sh, w);
      check("clock enable", sck_oe, 1);
      check("clock idle", sck_o, ckp_tb);
      bus(1'b0, `SCO_A_CTRL, 0);
      check("control", q, ctl | 32'h80);
    end
    // Master bytes land in the unread buffer; data line held still at one level
    bufv = sdi ? 32'hff : 0;
    rd_buf();
    conclude();
  end
endmodule
